// ==== hdl/power_saving_mode_control.sv ====
// power saving mode control: slow-down, idle, stop and hard sleep
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/100ps
`include "power_control_map.svh"
module power_saving_mode_control #(
  parameter int FINAL_RESET_CYCLES = `PCTL_FINAL_RESET_CYCLES
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  // avalon-mm slave
  input wire logic [`PCTL_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pins and system signals
  input wire logic hard_sleep_pin_n,
  input wire logic saving_lock_pin,
  input wire logic saving_lock_pin_driven,
  input wire logic reset_pin,
  input wire logic irq_pending,
  input wire logic main_osc_running,
  // clock gating and status
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic wdt_clk_en,
  output logic wdt_run,
  output logic wdt_reset_flag,
  output logic osc_wdt_flag,
  output logic osc_enable,
  output logic pins_float,
  output logic internal_reset,
  output logic program_store_strobe_n
);

  typedef struct packed {
    power_control_pkg::mode_t mode;
    logic [7:0] pctl;
    logic arm_prev;
    logic idle_arm_prev;
    logic slow_act;
    logic [1:0] slow_sync;
    logic [3:0] mc_cnt;
    logic [2:0] slow_cnt;
    logic [2:0] rst_cnt;
    logic [17:0] final_cnt;
    logic sleep_smp;
    logic lock_strap;
    logic wdt_run;
    logic wdt_flag;
    logic osc_flag;
    logic ack;
    logic [31:0] rdata;
  } state_t;

  state_t s_q, s_d;
  logic lock_lvl;
  logic mc_tick;
  logic base_tick;
  logic wr_pc;

  // a floating lock pin reads high: protection by default
  assign lock_lvl = saving_lock_pin_driven ? saving_lock_pin : 1'b1;
  assign mc_tick = (s_q.mc_cnt == `PCTL_CYCLES_PER_MACHINE - 4'h1);
  // derived clocks tick one in eight while slowed
  assign base_tick = !s_q.slow_act || (s_q.slow_cnt == 3'h0);
  // a write lands at the edge that sees waitrequest low, never earlier
  assign wr_pc = avs_write && s_q.ack &&
    (avs_address == `PCTL_OFS_POWER_CONTROL);

  function automatic logic bit_of(input logic [31:0] w, input int b);
    bit_of = w[b];
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.ack = (avs_read || avs_write) && !s_q.ack;
    s_d.slow_cnt = s_q.slow_cnt + 3'h1;
    if (base_tick) begin
      s_d.mc_cnt = mc_tick ? 4'h0 : s_q.mc_cnt + 4'h1;
    end
    if (mc_tick && base_tick) begin
      // hard sleep pin sampled once per machine cycle
      s_d.sleep_smp = !hard_sleep_pin_n;
      // slow-down synchronised over at most two machine cycles
      s_d.slow_sync = {s_q.slow_sync[0],
        s_q.pctl[`PCTL_BIT_CLOCK_SLOWDOWN]};
      s_d.slow_act = s_q.slow_sync[0];
    end
    if (avs_read && !s_q.ack) begin
      s_d.rdata = 32'h0000_0000;
      if (avs_address == `PCTL_OFS_POWER_CONTROL) begin
        s_d.rdata[7:0] = s_q.pctl;
      end else if (avs_address == `PCTL_OFS_STATUS) begin
        s_d.rdata[4:0] = s_q.mode;
        s_d.rdata[8] = s_q.wdt_run;
        s_d.rdata[9] = s_q.wdt_flag;
        s_d.rdata[10] = s_q.osc_flag;
        s_d.rdata[11] = lock_lvl;
      end
    end
    if (wr_pc) begin
      // register at 87 hex selects the modes
      s_d.arm_prev = 1'b0;
      s_d.idle_arm_prev = 1'b0;
      if (!lock_lvl) begin
        s_d.pctl[`PCTL_BIT_CLOCK_SLOWDOWN] =
          bit_of(avs_writedata, `PCTL_BIT_CLOCK_SLOWDOWN);
        // arm alone, trigger on the very next write
        if (bit_of(avs_writedata, `PCTL_BIT_STOP_TRIGGER) &&
            s_q.arm_prev) begin
          s_d.mode = power_control_pkg::ST_STOP;
        end
        s_d.arm_prev = bit_of(avs_writedata, `PCTL_BIT_STOP_ARM) &&
          !bit_of(avs_writedata, `PCTL_BIT_STOP_TRIGGER);
        // idle arm then trigger on consecutive writes
        if (bit_of(avs_writedata, `PCTL_BIT_CPU_HALT_TRIGGER) &&
            s_q.idle_arm_prev && s_q.mode == power_control_pkg::ST_RUN)
        begin
          s_d.mode = power_control_pkg::ST_IDLE;
        end
        s_d.idle_arm_prev = bit_of(avs_writedata, `PCTL_BIT_IDLE_ARM);
        s_d.pctl[`PCTL_BIT_IDLE_ARM] = s_d.idle_arm_prev;
      end
    end
    // stop arm and both triggers never stick in the register
    s_d.pctl[`PCTL_BIT_STOP_TRIGGER] = 1'b0;
    s_d.pctl[`PCTL_BIT_STOP_ARM] = 1'b0;
    s_d.pctl[`PCTL_BIT_CPU_HALT_TRIGGER] = 1'b0;
    unique case (s_q.mode)
      power_control_pkg::ST_RUN: begin
      end
      power_control_pkg::ST_IDLE: begin
        // enabled interrupt ends idle, cpu resumes in place
        if (irq_pending) begin
          s_d.mode = power_control_pkg::ST_RUN;
        end
      end
      power_control_pkg::ST_STOP: begin
      end
      power_control_pkg::ST_HW_RESET: begin
        s_d.rst_cnt = s_q.rst_cnt + 3'h1;
        if (s_q.rst_cnt >= `PCTL_RESET_MACHINE_CYCLES) begin
          // oscillators stop only after the internal reset
          s_d.mode = power_control_pkg::ST_HW_SLEEP;
        end
      end
      power_control_pkg::ST_HW_SLEEP: begin
        if (hard_sleep_pin_n) begin
          // restart: reset held until oscillator settled
          if (!main_osc_running) begin
            s_d.final_cnt = 18'h0_0000;
          end else if (s_q.final_cnt ==
                       18'(FINAL_RESET_CYCLES - 1)) begin
            s_d.mode = power_control_pkg::ST_RUN;
            s_d.osc_flag = 1'b1;
            s_d.wdt_run = s_q.lock_strap;
          end else begin
            s_d.final_cnt = s_q.final_cnt + 18'h0_0001;
          end
        end
      end
      default: s_d.mode = power_control_pkg::ST_RUN;
    endcase
    // hard sleep entry: full internal reset first
    if (s_q.sleep_smp && mc_tick && base_tick &&
        s_q.mode != power_control_pkg::ST_HW_RESET &&
        s_q.mode != power_control_pkg::ST_HW_SLEEP) begin
      s_d.mode = power_control_pkg::ST_HW_RESET;
      s_d.rst_cnt = 3'h0;
      s_d.final_cnt = 18'h0_0000;
      s_d.wdt_run = 1'b0;
      s_d.wdt_flag = 1'b0;
      s_d.pctl = `PCTL_RESET_POWER_CONTROL;
    end
    // reset pin wins over idle, stop and hard sleep
    if (reset_pin) begin
      s_d.mode = power_control_pkg::ST_RUN;
      s_d.pctl = `PCTL_RESET_POWER_CONTROL;
      s_d.arm_prev = 1'b0;
      s_d.idle_arm_prev = 1'b0;
      s_d.slow_sync = 2'b00;
      s_d.slow_act = 1'b0;
      s_d.wdt_flag = 1'b0;
      // strap caught while reset is held, watchdog auto-starts when it is high
      s_d.lock_strap = lock_lvl;
      s_d.wdt_run = lock_lvl;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.mode <= power_control_pkg::ST_RUN;
      s_q.pctl <= `PCTL_RESET_POWER_CONTROL;
      s_q.lock_strap <= 1'b1;
      s_q.wdt_run <= 1'b1;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // one wait cycle, then the answer is returned
  assign avs_waitrequest = (avs_read || avs_write) && !s_q.ack;
  assign avs_readdata = s_q.rdata;
  // cpu stopped in idle, stop and hard sleep
  assign cpu_clk_en = base_tick && (s_q.mode == power_control_pkg::ST_RUN);
  assign periph_clk_en = base_tick &&
    (s_q.mode == power_control_pkg::ST_RUN ||
     s_q.mode == power_control_pkg::ST_IDLE ||
     s_q.mode == power_control_pkg::ST_HW_RESET);
  // watchdog, unlike the peripherals, loses its clock in idle
  assign wdt_clk_en = base_tick && s_q.wdt_run &&
    (s_q.mode == power_control_pkg::ST_RUN);
  assign wdt_run = s_q.wdt_run;
  assign wdt_reset_flag = s_q.wdt_flag;
  assign osc_wdt_flag = s_q.osc_flag;
  assign osc_enable = (s_q.mode != power_control_pkg::ST_STOP) &&
    !(s_q.mode == power_control_pkg::ST_HW_SLEEP && !hard_sleep_pin_n);
  assign pins_float = (s_q.mode == power_control_pkg::ST_HW_SLEEP) &&
    !hard_sleep_pin_n;
  assign internal_reset = (s_q.mode == power_control_pkg::ST_HW_RESET) ||
    (s_q.mode == power_control_pkg::ST_HW_SLEEP);
  // strobe held high in idle; low in stop
  assign program_store_strobe_n =
    (s_q.mode != power_control_pkg::ST_STOP);

  // assertions
  wdt_idle_gate_a: assert property (@(posedge ref_clk) disable iff (srst)
    s_q.mode == power_control_pkg::ST_IDLE |-> !wdt_clk_en)
    else $error("watchdog clocked in idle");
  cpu_idle_gate_a: assert property (@(posedge ref_clk) disable iff (srst)
    s_q.mode == power_control_pkg::ST_IDLE |-> !cpu_clk_en &&
    periph_clk_en == base_tick)
    else $error("idle clock gating wrong");
  stop_bits_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
    !s_q.pctl[`PCTL_BIT_STOP_ARM] && !s_q.pctl[`PCTL_BIT_STOP_TRIGGER])
    else $error("stop bits stuck");
  stop_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    s_q.mode == power_control_pkg::ST_STOP && !reset_pin && clk_en &&
    !(s_q.sleep_smp && mc_tick) |=> s_q.mode == power_control_pkg::ST_STOP)
    else $error("stop left without reset");
  lock_block_a: assert property (@(posedge ref_clk) disable iff (srst)
    lock_lvl && s_q.mode == power_control_pkg::ST_RUN && !reset_pin
    |=> s_q.mode != power_control_pkg::ST_IDLE &&
    s_q.mode != power_control_pkg::ST_STOP)
    else $error("software mode entered while locked");
  reset_override_a: assert property (@(posedge ref_clk) disable iff (srst)
    reset_pin && clk_en |=> s_q.mode == power_control_pkg::ST_RUN)
    else $error("reset did not end mode");
  float_pins_a: assert property (@(posedge ref_clk) disable iff (srst)
    pins_float |-> !osc_enable && internal_reset)
    else $error("float without oscillator stop");
  sleep_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(s_q.mode == power_control_pkg::ST_HW_RESET)
    |-> !s_q.wdt_run && !s_q.wdt_flag)
    else $error("sleep reset kept watchdog");
  bus_answer_a: assert property (@(posedge ref_clk) disable iff (srst)
    (avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest)
    else $error("bus answer late");
  idle_cover_c: cover property (@(posedge ref_clk)
    s_q.mode == power_control_pkg::ST_IDLE);
  stop_cover_c: cover property (@(posedge ref_clk)
    s_q.mode == power_control_pkg::ST_STOP);
  sleep_cover_c: cover property (@(posedge ref_clk) $rose(osc_wdt_flag));
  slow_cover_c: cover property (@(posedge ref_clk) s_q.slow_act);

endmodule // power_saving_mode_control

// ==== hdl/power_control_map.svh ====
// register offsets, field positions and timing counts of the power control
`ifndef POWER_CONTROL_MAP_SVH
`define POWER_CONTROL_MAP_SVH
`define PCTL_ADDR_W 8
`define PCTL_OFS_POWER_CONTROL 8'h87
`define PCTL_OFS_STATUS 8'h88
`define PCTL_BIT_STOP_TRIGGER 0
`define PCTL_BIT_STOP_ARM 1
`define PCTL_BIT_CPU_HALT_TRIGGER 2
`define PCTL_BIT_IDLE_ARM 3
`define PCTL_BIT_CLOCK_SLOWDOWN 4
`define PCTL_RESET_POWER_CONTROL 8'h00
`define PCTL_CYCLES_PER_MACHINE 4'hC
`define PCTL_SLOW_DIVIDE 4'h8
`define PCTL_SYNC_MACHINE_CYCLES 2
`define PCTL_RESET_MACHINE_CYCLES 3'h2
`define PCTL_FINAL_RESET_NS 250000
`define PCTL_CLK_PERIOD_NS 20
`define PCTL_FINAL_RESET_CYCLES (`PCTL_FINAL_RESET_NS / `PCTL_CLK_PERIOD_NS)
`endif

// ==== hdl/power_control_pkg.sv ====
// types of the power saving mode control block
package power_control_pkg;
  typedef enum logic [4:0] {
    ST_RUN = 5'b00001,
    ST_IDLE = 5'b00010,
    ST_STOP = 5'b00100,
    ST_HW_RESET = 5'b01000,
    ST_HW_SLEEP = 5'b10000
  } mode_t;
endpackage

// ==== testbench/sys_pins_model.sv ====
// board side model: drives the sleep, reset and oscillator pins
`timescale 1ns/100ps
module sys_pins_model #(
  parameter int OSC_START = 60
) (
  // clock
  input wire logic ref_clk,
  // requests from the bench
  input wire logic sleep_req,
  input wire logic rst_req,
  // pins
  output logic hard_sleep_pin_n,
  output logic reset_pin,
  output logic main_osc_running
);
  int osc_cnt = OSC_START;
  int rst_cnt = 24;
  initial begin
    hard_sleep_pin_n = 1'b1;
    reset_pin = 1'b0;
    main_osc_running = 1'b1;
  end
  always @(posedge ref_clk) begin
    hard_sleep_pin_n <= !sleep_req;
    // never reset while asleep; a pulse lasts 25 clocks, just over two machine cycles
    if (rst_req && hard_sleep_pin_n) begin
      reset_pin <= 1'b1;
      rst_cnt <= 0;
    end else if (rst_cnt < 24) begin
      rst_cnt <= rst_cnt + 1;
    end else begin
      reset_pin <= 1'b0;
    end
    // crystal needs a while to start after sleep ends
    if (!hard_sleep_pin_n) begin
      osc_cnt <= 0;
      main_osc_running <= 1'b0;
    end else if (osc_cnt < OSC_START) begin
      osc_cnt <= osc_cnt + 1;
    end else begin
      main_osc_running <= 1'b1;
    end
  end
endmodule // sys_pins_model

// ==== testbench/tb.sv ====
// self-checking bench of the power saving mode control
`timescale 1ns/100ps
`include "power_control_map.svh"
module tb;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic lock = 1'b0;
  logic lock_drv = 1'b0;
  logic irq = 1'b0;
  logic sleep_req = 1'b0;
  logic rst_req = 1'b0;
  logic clk_en = 1'b1;
  logic hs_n, rpin, osc_ok, cpu_en, per_en, wdt_en, wdt_run, wdt_flag;
  logic osc_flag, osc_en, pfloat, irst, pss_n;
  logic [31:0] exp_q[$];
  logic [7:0] ra;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int c;
  integer seed = 32'hc924;

  always #10 ref_clk = ~ref_clk;

  power_saving_mode_control #(.FINAL_RESET_CYCLES(8))
    power_saving_mode_control_inst (.ref_clk(ref_clk), .srst(srst),
    .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .hard_sleep_pin_n(hs_n), .saving_lock_pin(lock),
    .saving_lock_pin_driven(lock_drv), .reset_pin(rpin),
    .irq_pending(irq), .main_osc_running(osc_ok), .cpu_clk_en(cpu_en),
    .periph_clk_en(per_en), .wdt_clk_en(wdt_en), .wdt_run(wdt_run),
    .wdt_reset_flag(wdt_flag), .osc_wdt_flag(osc_flag),
    .osc_enable(osc_en), .pins_float(pfloat), .internal_reset(irst),
    .program_store_strobe_n(pss_n));

  sys_pins_model sys_pins_model_inst (.ref_clk(ref_clk),
    .sleep_req(sleep_req), .rst_req(rst_req), .hard_sleep_pin_n(hs_n),
    .reset_pin(rpin), .main_osc_running(osc_ok));

  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // request held until the edge that sees waitrequest low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    // judged mid-cycle, so the next rising edge is the accepting one
    do @(negedge ref_clk); while (avs_waitrequest !== 1'b0);
    @(posedge ref_clk);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  task wr(input logic [31:0] d);
    bus(1'b1, `PCTL_OFS_POWER_CONTROL, d);
  endtask

  task pulses(output int n);
    n = 0;
    repeat (96) begin
      @(posedge ref_clk);
      if (cpu_en === 1'b1) n++;
    end
  endtask

  always @(negedge ref_clk) begin
    if (avs_read && !avs_waitrequest) chk("readdata", exp_q.pop_front(),
      avs_readdata);
  end

  // sized for under a thousand cycles of tests
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    rd(8'h88, 32'h0000_0901);
    ra = $random(seed);
    if (ra == 8'h87 || ra == 8'h88) ra = 8'h40;
    bus(1'b1, ra, $random(seed));
    rd(ra, 32'h0000_0000);
    rd(`PCTL_OFS_POWER_CONTROL, 32'h0000_0000);
    wr(32'h0000_0008);
    wr(32'h0000_0004);
    rd(8'h88, 32'h0000_0901);
    lock_drv <= 1'b1;
    rd(8'h88, 32'h0000_0101);
    wr(32'h0000_0008);
    wr(32'h0000_0004);
    #1;
    chk("cpu_clk_en", 0, cpu_en);
    chk("periph_clk_en", 1, per_en);
    chk("wdt_clk_en", 0, wdt_en);
    chk("strobe_n", 1, pss_n);
    rd(8'h88, 32'h0000_0102);
    @(posedge ref_clk);
    irq <= 1'b1;
    repeat (3) @(posedge ref_clk);
    irq <= 1'b0;
    rd(8'h88, 32'h0000_0101);
    wr(32'h0000_0003);
    wr(32'h0000_0001);
    rd(8'h88, 32'h0000_0101);
    wr(32'h0000_0002);
    wr(32'h0000_0001);
    #1;
    chk("strobe_n", 0, pss_n);
    chk("cpu_clk_en", 0, cpu_en);
    @(posedge ref_clk);
    rst_req <= 1'b1;
    @(posedge ref_clk);
    rst_req <= 1'b0;
    repeat (30) @(posedge ref_clk);
    rd(`PCTL_OFS_POWER_CONTROL, 32'h0000_0000);
    rd(8'h88, 32'h0000_0001);
    wr(32'h0000_0010);
    repeat (192) @(posedge ref_clk);
    pulses(c);
    chk("slow pulses", 12, c);
    wr(32'h0000_0000);
    repeat (192) @(posedge ref_clk);
    pulses(c);
    chk("full pulses", 96, c);
    lock <= 1'b1;
    wr(32'h0000_0010);
    rd(`PCTL_OFS_POWER_CONTROL, 32'h0000_0000);
    rd(8'h88, 32'h0000_0801);
    sleep_req <= 1'b1;
    repeat (100) begin
      @(posedge ref_clk);
      if (pfloat === 1'b1) break;
    end
    #1;
    chk("pins_float", 1, pfloat);
    chk("osc_enable", 0, osc_en);
    chk("wdt_run", 0, wdt_run);
    chk("wdt_reset_flag", 0, wdt_flag);
    @(posedge ref_clk);
    sleep_req <= 1'b0;
    repeat (30) @(posedge ref_clk);
    #1;
    chk("pins_float", 0, pfloat);
    chk("osc_enable", 1, osc_en);
    chk("internal_reset", 1, irst);
    repeat (300) begin
      @(posedge ref_clk);
      if (irst === 1'b0) break;
    end
    rd(8'h88, 32'h0000_0C01);
    chk("osc_wdt_flag", 1, osc_flag);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    rst_req <= 1'b1;
    @(posedge ref_clk);
    rst_req <= 1'b0;
    repeat (30) @(posedge ref_clk);
    #1;
    chk("frozen wdt_run", 0, wdt_run);
    clk_en <= 1'b1;
    report_and_stop();
  end
endmodule // tb
